// file: hdl/tdb_unit.sv
// tile debug breakpoint unit: apb registers, comparators, cause capture
`include "tdb_consts.svh"
module tdb_unit #(
  parameter int NUNITS = 4,
  parameter int NTHREADS = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // thread activity
  input wire tdb_pkg::tdb_fetch_t FETCH,
  input wire tdb_pkg::tdb_mem_t MEM,
  input wire tdb_pkg::tdb_res_t RES,
  input wire tdb_pkg::tdb_call_t CALL,
  input wire logic HOST_REQ,
  input wire logic DEBUG_RETURN,
  // tile configuration scratch port
  input wire logic CFG_SCR_WE,
  input wire logic [2:0] CFG_SCR_IDX,
  input wire logic [31:0] CFG_SCR_WDATA,
  output logic [31:0] CFG_SCR_RDATA,
  // debug outputs
  output logic DEBUG_IRQ,
  output logic IN_DEBUG,
  output logic [7:0] THREAD_RUN_EN,
  output logic [7:0] GETREG_THREAD,
  output logic [4:0] GETREG_INDEX
);
  logic [31:0] scratch [8];
  logic [31:0] ib_addr [NUNITS];
  logic [31:0] ib_ctrl [NUNITS];
  logic [31:0] dw_addr1 [NUNITS];
  logic [31:0] dw_addr2 [NUNITS];
  logic [31:0] dw_ctrl [NUNITS];
  logic [31:0] rw_mask [NUNITS];
  logic [31:0] rw_value [NUNITS];
  logic [31:0] rw_ctrl [NUNITS];
  logic [7:0] thread_selector;
  logic [4:0] register_index_field;
  logic [2:0] interrupt_cause_code;
  logic [1:0] hit_index;
  logic [7:0] cause_thread;
  logic [31:0] irq_data;
  logic [7:0] stop_mask;
  tdb_pkg::tdb_mode_t mode;
  logic [NUNITS-1:0] ib_hit;
  logic [NUNITS-1:0] dw_hit;
  logic [NUNITS-1:0] rw_hit;
  logic access;
  logic aligned;
  logic wr;
  logic [7:0] idx;
  logic [31:0] next_rdata;
  logic mapped;
  logic take;
  logic [2:0] next_cause;
  logic [1:0] next_index;
  logic [7:0] next_thread;
  logic [31:0] next_data;

  // thread enable and unit enable both required
  function automatic logic armed(input logic [31:0] ctrl,
                                 input logic [2:0] thr);
    logic [7:0] thr_en;
    thr_en = ctrl[`TDB_THR_MSB:`TDB_THR_LSB];
    armed = ctrl[`TDB_EN_BIT] & thr_en[thr]; // RQ24 RQ14 RQ18 RQ21
  endfunction

  // lowest set bit wins
  function automatic logic [1:0] lowest(input logic [NUNITS-1:0] v);
    lowest = 2'h0;
    for (int i = NUNITS - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 2'(i); // RQ5
      end
    end
  endfunction

  // register in a 4-word array window
  function automatic logic in_arr(input logic [7:0] a, input logic [7:0] b);
    in_arr = (a >= b) && (a < b + 8'(NUNITS));
  endfunction

  // register in the 8-word scratch window
  function automatic logic in_scr(input logic [7:0] a);
    in_scr = (a >= `TDB_SCRATCH_IDX) && (a < `TDB_SCRATCH_IDX + 8'h08);
  endfunction

  // refused addresses must not write either
  assign aligned = PADDR[11:10] == 2'h0 && PADDR[1:0] == 2'h0;
  assign access = PSEL & PENABLE;
  assign wr = access & PWRITE & aligned;
  assign idx = PADDR[9:2];

  // the pc compare mode 1 operator is unreadable; inequality is taken
  always_comb begin
    for (int i = 0; i < NUNITS; i++) begin
      ib_hit[i] = FETCH.valid && armed(ib_ctrl[i], FETCH.thread) &&
                  (ib_ctrl[i][`TDB_COND_BIT] ? (FETCH.pc != ib_addr[i])
                                            : (FETCH.pc == ib_addr[i]));
      // RQ11 RQ12 RQ13 RQ22
    end
  end

  // data watch: a is addr at or above first, b at or below second
  always_comb begin
    for (int i = 0; i < NUNITS; i++) begin
      dw_hit[i] = MEM.valid && armed(dw_ctrl[i], MEM.thread) &&
                  (!MEM.load || dw_ctrl[i][`TDB_LOAD_BIT]) && // RQ17
                  (dw_ctrl[i][`TDB_COND_BIT]
                   ? (MEM.addr >= dw_addr1[i]) || (MEM.addr <= dw_addr2[i])
                   : (MEM.addr >= dw_addr1[i]) && (MEM.addr <= dw_addr2[i]));
      // RQ15 RQ16
    end
  end

  // resource watch: masked identifier against value
  always_comb begin
    for (int i = 0; i < NUNITS; i++) begin
      rw_hit[i] = RES.valid && armed(rw_ctrl[i], RES.thread) &&
                  (rw_ctrl[i][`TDB_COND_BIT]
                   ? ((RES.res_id & rw_mask[i]) != rw_value[i])
                   : ((RES.res_id & rw_mask[i]) == rw_value[i]));
      // RQ19 RQ20 RQ23
    end
  end

  // cause priority: host, call, ibreak, data, resource
  always_comb begin
    take = mode == tdb_pkg::TDB_RUN;
    next_cause = 3'h0;
    next_index = 2'h0;
    next_thread = 8'h00;
    next_data = irq_data;
    if (HOST_REQ) begin
      next_cause = `TDB_CAUSE_HOST; // RQ3 RQ6
    end else if (CALL.valid) begin
      next_cause = `TDB_CAUSE_CALL; // RQ4
      next_thread = {5'h00, CALL.thread};
    end else if (|ib_hit) begin
      next_cause = `TDB_CAUSE_IBRK;
      next_index = lowest(ib_hit); // RQ4 RQ5
      next_thread = {5'h00, FETCH.thread};
    end else if (|dw_hit) begin
      next_cause = `TDB_CAUSE_DWAT;
      next_index = lowest(dw_hit);
      next_thread = {5'h00, MEM.thread};
      next_data = MEM.addr; // RQ7
    end else if (|rw_hit) begin
      next_cause = `TDB_CAUSE_RWAT;
      next_index = lowest(rw_hit);
      next_thread = {5'h00, RES.thread};
      next_data = RES.res_id; // RQ8
    end else begin
      take = 1'b0;
    end
  end

  // entry into and return from debug mode
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode <= tdb_pkg::TDB_RUN;
      DEBUG_IRQ <= 1'b0;
    end else begin
      DEBUG_IRQ <= take;
      if (take) begin
        mode <= tdb_pkg::TDB_DEBUG;
      end else if (DEBUG_RETURN) begin
        mode <= tdb_pkg::TDB_RUN;
      end
    end
  end

  // cause record: hardware capture wins over software write
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      interrupt_cause_code <= 3'h0;
      hit_index <= 2'h0;
      cause_thread <= 8'h00;
      irq_data <= 32'h0;
    end else if (take) begin
      interrupt_cause_code <= next_cause; // RQ3
      hit_index <= next_index; // RQ4
      cause_thread <= next_thread; // RQ6
      irq_data <= next_data; // RQ7 RQ8
    end else if (wr) begin
      if (idx == `TDB_CAUSE_IDX) begin
        interrupt_cause_code <= PWDATA[2:0];
        hit_index <= PWDATA[`TDB_IDX_MSB:`TDB_IDX_LSB];
        cause_thread <= PWDATA[`TDB_TNUM_MSB:`TDB_TNUM_LSB];
      end
      if (idx == `TDB_DATA_IDX) begin
        irq_data <= PWDATA;
      end
    end
  end

  // register-read operands
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      thread_selector <= 8'h00;
      register_index_field <= 5'h00;
    end else if (wr) begin
      if (idx == `TDB_THREAD_SEL_IDX) begin
        thread_selector <= PWDATA[7:0]; // RQ1
      end
      if (idx == `TDB_REG_INDEX_IDX) begin
        register_index_field <= PWDATA[4:0]; // RQ2
      end
    end
  end

  // stop mask, applied on debug return
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stop_mask <= 8'h00;
    end else if (wr && idx == `TDB_STOP_MASK_IDX) begin
      stop_mask <= PWDATA[7:0]; // RQ9
    end
  end

  // scratch: apb write wins over tile configuration write
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) begin
        scratch[i] <= 32'h0;
      end
    end else if (wr && in_scr(idx)) begin
      scratch[idx[2:0]] <= PWDATA; // RQ10
    end else if (CFG_SCR_WE) begin
      scratch[CFG_SCR_IDX] <= CFG_SCR_WDATA; // RQ10
    end
  end

  // instruction breakpoint registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUNITS; i++) begin
        ib_addr[i] <= 32'h0;
        ib_ctrl[i] <= 32'h0;
      end
    end else if (wr) begin
      for (int i = 0; i < NUNITS; i++) begin
        if (idx == `TDB_IBADDR_IDX + 8'(i)) begin
          ib_addr[i] <= PWDATA; // RQ12
        end
        if (idx == `TDB_IBCTRL_IDX + 8'(i)) begin
          ib_ctrl[i] <= PWDATA & `TDB_CTRL_MASK; // RQ13
        end
      end
    end
  end

  // data watch registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUNITS; i++) begin
        dw_addr1[i] <= 32'h0;
        dw_addr2[i] <= 32'h0;
        dw_ctrl[i] <= 32'h0;
      end
    end else if (wr) begin
      for (int i = 0; i < NUNITS; i++) begin
        if (idx == `TDB_DWADDR1_IDX + 8'(i)) begin
          dw_addr1[i] <= PWDATA;
        end
        if (idx == `TDB_DWADDR2_IDX + 8'(i)) begin
          dw_addr2[i] <= PWDATA;
        end
        if (idx == `TDB_DWCTRL_IDX + 8'(i)) begin
          dw_ctrl[i] <= PWDATA & `TDB_DWCTRL_MASK; // RQ18
        end
      end
    end
  end

  // resource watch registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUNITS; i++) begin
        rw_mask[i] <= 32'h0;
        rw_value[i] <= 32'h0;
        rw_ctrl[i] <= 32'h0;
      end
    end else if (wr) begin
      for (int i = 0; i < NUNITS; i++) begin
        if (idx == `TDB_RWMASK_IDX + 8'(i)) begin
          rw_mask[i] <= PWDATA;
        end
        if (idx == `TDB_RWVALUE_IDX + 8'(i)) begin
          rw_value[i] <= PWDATA;
        end
        if (idx == `TDB_RWCTRL_IDX + 8'(i)) begin
          rw_ctrl[i] <= PWDATA & `TDB_CTRL_MASK; // RQ21
        end
      end
    end
  end

  // read mux
  always_comb begin
    next_rdata = 32'h0;
    mapped = 1'b1;
    if (idx == `TDB_THREAD_SEL_IDX) begin
      next_rdata = {24'h0, thread_selector};
    end else if (idx == `TDB_REG_INDEX_IDX) begin
      next_rdata = {27'h0, register_index_field};
    end else if (idx == `TDB_CAUSE_IDX) begin
      next_rdata = {14'h0, hit_index, cause_thread, 5'h00,
                    interrupt_cause_code};
    end else if (idx == `TDB_DATA_IDX) begin
      next_rdata = irq_data;
    end else if (idx == `TDB_STOP_MASK_IDX) begin
      next_rdata = {24'h0, stop_mask};
    end else if (in_scr(idx)) begin
      next_rdata = scratch[idx[2:0]];
    end else if (in_arr(idx, `TDB_IBADDR_IDX)) begin
      next_rdata = ib_addr[idx[1:0]];
    end else if (in_arr(idx, `TDB_IBCTRL_IDX)) begin
      next_rdata = ib_ctrl[idx[1:0]];
    end else if (in_arr(idx, `TDB_DWADDR1_IDX)) begin
      next_rdata = dw_addr1[idx[1:0]];
    end else if (in_arr(idx, `TDB_DWADDR2_IDX)) begin
      next_rdata = dw_addr2[idx[1:0]];
    end else if (in_arr(idx, `TDB_DWCTRL_IDX)) begin
      next_rdata = dw_ctrl[idx[1:0]];
    end else if (in_arr(idx, `TDB_RWMASK_IDX)) begin
      next_rdata = rw_mask[idx[1:0]];
    end else if (in_arr(idx, `TDB_RWVALUE_IDX)) begin
      next_rdata = rw_value[idx[1:0]];
    end else if (in_arr(idx, `TDB_RWCTRL_IDX)) begin
      next_rdata = rw_ctrl[2'(idx - `TDB_RWCTRL_IDX)];
    end else begin
      mapped = 1'b0;
    end
    if (!aligned) begin
      mapped = 1'b0;
      next_rdata = 32'h0;
    end
  end

  // apb answer registered: no wait state, pready high in the first access cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PRDATA <= (PSEL & ~PENABLE & ~PWRITE) ? next_rdata : 32'h0;
      PSLVERR <= PSEL & ~PENABLE & ~mapped;
    end
  end

  // debug status and run enables
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IN_DEBUG <= 1'b0;
      THREAD_RUN_EN <= 8'h00;
    end else begin
      IN_DEBUG <= mode == tdb_pkg::TDB_DEBUG;
      THREAD_RUN_EN <= (mode == tdb_pkg::TDB_DEBUG || take)
                       ? 8'h00 : ~stop_mask; // RQ9
    end
  end

  // operand and scratch copies
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      GETREG_THREAD <= 8'h00;
      GETREG_INDEX <= 5'h00;
      CFG_SCR_RDATA <= 32'h0;
    end else begin
      GETREG_THREAD <= thread_selector;
      GETREG_INDEX <= register_index_field;
      CFG_SCR_RDATA <= scratch[CFG_SCR_IDX];
    end
  end
endmodule

// file: hdl/tdb_consts.svh
// register map, fields and codes of the tile debug breakpoint unit
// Overview of operation
// RQ1: an 8-bit thread selector names the core read by register-read.
// RQ2: a 5-bit register index selects which register register-read returns.
// RQ3: each debug interrupt records cause: host 1, call 2, ibreak 3, data 4, res 5.
// RQ4: a 2-bit field records the firing unit index, zero for host and call.
// RQ5: simultaneous hits report the lowest-numbered unit.
// RQ6: an 8-bit field records the causing thread, zero for host requests.
// RQ7: a data watch hit captures the effective address into interrupt data.
// RQ8: a resource watch hit captures the resource identifier into interrupt data.
// RQ9: an 8-bit stop mask keeps set threads stopped after debug return.
// RQ10: eight 32-bit scratch words, also reachable from tile configuration.
// RQ11: a thread's pc meeting the compare against ibreak address interrupts.
// RQ12: four independent instruction breakpoints with address and control.
// RQ13: ibreak control: thread enables 23:16, enable bit 0, mode bit 1.
// RQ14: an ibreak fires only when its enable bit is one; resets zero.
// RQ15: four data watchpoints each with first and second address.
// RQ16: data watch condition bit: 0 needs A and B, 1 either.
// RQ17: data watch fires on loads only when its load bit 2 is set.
// RQ18: data watch control: thread enables 23:16 and enable bit 0.
// RQ19: four resource watchpoints with mask and value registers.
// RQ20: resource watch condition bit 1: 0 uses condition A, 1 B.
// RQ21: resource watch control: thread enables 23:16, enable bit 0.
// RQ22: a breakpoint control governs allowed cores and compare condition.
// RQ23: resource condition compares masked identifier against value.
// RQ24: a unit fires only with both thread enable and its enable set.
`ifndef TDB_CONSTS_SVH
`define TDB_CONSTS_SVH
`define TDB_THREAD_SEL_IDX 8'h13
`define TDB_REG_INDEX_IDX 8'h14
`define TDB_CAUSE_IDX 8'h15
`define TDB_DATA_IDX 8'h16
`define TDB_STOP_MASK_IDX 8'h18
`define TDB_SCRATCH_IDX 8'h20
`define TDB_IBADDR_IDX 8'h30
`define TDB_IBCTRL_IDX 8'h40
`define TDB_DWADDR1_IDX 8'h50
`define TDB_DWADDR2_IDX 8'h60
`define TDB_DWCTRL_IDX 8'h70
`define TDB_RWMASK_IDX 8'h80
`define TDB_RWVALUE_IDX 8'h90
`define TDB_RWCTRL_IDX 8'h9c
`define TDB_EN_BIT 0
`define TDB_COND_BIT 1
`define TDB_LOAD_BIT 2
`define TDB_THR_LSB 16
`define TDB_THR_MSB 23
`define TDB_IDX_LSB 16
`define TDB_IDX_MSB 17
`define TDB_TNUM_LSB 8
`define TDB_TNUM_MSB 15
`define TDB_CTRL_MASK 32'h00ff0003
`define TDB_DWCTRL_MASK 32'h00ff0007
`define TDB_CAUSE_HOST 3'h1
`define TDB_CAUSE_CALL 3'h2
`define TDB_CAUSE_IBRK 3'h3
`define TDB_CAUSE_DWAT 3'h4
`define TDB_CAUSE_RWAT 3'h5
`endif

// file: hdl/tdb_pkg.sv
// types of the tile debug breakpoint unit
package tdb_pkg;
  typedef struct packed {
    logic valid;
    logic [2:0] thread;
    logic [31:0] pc;
  } tdb_fetch_t;
  typedef struct packed {
    logic valid;
    logic load;
    logic [2:0] thread;
    logic [31:0] addr;
  } tdb_mem_t;
  typedef struct packed {
    logic valid;
    logic [2:0] thread;
    logic [31:0] res_id;
  } tdb_res_t;
  typedef struct packed {
    logic valid;
    logic [2:0] thread;
  } tdb_call_t;
  typedef enum logic [0:0] {
    TDB_RUN = 1'b0,
    TDB_DEBUG = 1'b1
  } tdb_mode_t;
endpackage

// file: testbench/tdb_unit_assertions.sv
// port-level assertions of the tile debug breakpoint unit
module tdb_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // activity and scratch port
  input wire logic HOST_REQ,
  input wire logic CFG_SCR_WE,
  input wire logic [2:0] CFG_SCR_IDX,
  input wire logic [31:0] CFG_SCR_WDATA,
  input wire logic [31:0] CFG_SCR_RDATA,
  // debug outputs
  input wire logic DEBUG_IRQ,
  input wire logic IN_DEBUG,
  input wire logic [7:0] THREAD_RUN_EN,
  input wire logic [7:0] GETREG_THREAD,
  input wire logic [4:0] GETREG_INDEX
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  logic wr_done;
  logic [7:0] stop_sh;
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  // shadow of the stop mask as software wrote it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stop_sh <= 8'h00;
    end else if (wr_done && PADDR == 12'h060) begin
      stop_sh <= PWDATA[7:0];
    end
  end
  a_pready_timing: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("pready missing after setup");
  a_prdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("prdata not zero outside access");
  a_unmapped_err: assert property (PSEL && !PENABLE && PADDR == 12'h05c
    |=> PREADY && PSLVERR)
    else $error("unmapped access not refused");
  a_getreg_index: assert property (wr_done && PADDR == 12'h050
    |=> ##1 {27'h0, GETREG_INDEX} == ($past(PWDATA, 2) & 32'h1f))
    else $error("register index operand wrong");
  a_getreg_thread: assert property (wr_done && PADDR == 12'h04c
    |=> ##1 {24'h0, GETREG_THREAD} == ($past(PWDATA, 2) & 32'hff))
    else $error("thread selector operand wrong");
  a_host_irq: assert property (!IN_DEBUG && !DEBUG_IRQ && HOST_REQ
    |=> DEBUG_IRQ)
    else $error("host request not taken");
  a_enter_debug: assert property (DEBUG_IRQ |-> ##[0:1] IN_DEBUG)
    else $error("debug mode not entered");
  a_stop_all: assert property (IN_DEBUG && $past(IN_DEBUG)
    |-> THREAD_RUN_EN == 8'h00 && !DEBUG_IRQ)
    else $error("threads run or interrupt taken in debug");
  a_run_mask: assert property ($fell(IN_DEBUG)
    |-> ##1 THREAD_RUN_EN == ~stop_sh)
    else $error("run enables differ from stop mask");
  a_cfg_scratch: assert property (CFG_SCR_WE ##1 $stable(CFG_SCR_IDX)
    |=> CFG_SCR_RDATA == $past(CFG_SCR_WDATA, 2))
    else $error("config scratch readback wrong");
  cover property (DEBUG_IRQ);
  cover property ($fell(IN_DEBUG));
  cover property (PSLVERR);
endmodule
bind tdb_unit tdb_chk u_chk (.*);

// file: testbench/tdb_threads.sv
// thread-side model: one event per request, idle fields scrambled
module tdb_threads (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [2:0] thr,
  input wire logic [31:0] val,
  input wire logic ld,
  // thread activity
  output tdb_pkg::tdb_fetch_t fetch,
  output tdb_pkg::tdb_mem_t mem,
  output tdb_pkg::tdb_res_t res,
  output tdb_pkg::tdb_call_t call,
  output logic host,
  output logic ret
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] junk = 32'h0;
  initial begin
    fetch = '0;
    mem = '0;
    res = '0;
    call = '0;
    host = 1'b0;
    ret = 1'b0;
  end
  always @(posedge clk) begin
    junk <= junk + 32'h9e3779b9;
    fetch <= {1'b0, junk[2:0], junk};
    mem <= {1'b0, junk[9], junk[2:0], junk};
    res <= {1'b0, junk[5:3], ~junk};
    call <= {1'b0, junk[8:6]};
    host <= 1'b0;
    ret <= 1'b0;
    if (go) begin
      case (kind)
        3'h0: host <= 1'b1;
        3'h1: call <= {1'b1, thr};
        3'h2: fetch <= {1'b1, thr, val};
        3'h3: mem <= {1'b1, ld, thr, val};
        3'h4: res <= {1'b1, thr, val};
        default: ret <= 1'b1;
      endcase
    end
  end
endmodule

// file: testbench/tb_tile_debug_breakpoint_unit.sv
// self-checking bench of the tile debug breakpoint unit
module tb_tile_debug_breakpoint_unit;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, host, ret, irq, in_dbg;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, cwd = 32'h0, crd, val = 32'h0;
  logic cwe = 1'b0, go = 1'b0, ld = 1'b0;
  logic [2:0] cidx = 3'h0, kind = 3'h0, thr = 3'h0;
  logic [7:0] run_en, gthr;
  logic [4:0] gidx;
  tdb_pkg::tdb_fetch_t fetch;
  tdb_pkg::tdb_mem_t mem;
  tdb_pkg::tdb_res_t res;
  tdb_pkg::tdb_call_t call;
  int mismatches = 0, checks = 0;
  always #12.5 clk = ~clk;
  tdb_unit dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FETCH(fetch), .MEM(mem),
    .RES(res), .CALL(call), .HOST_REQ(host), .DEBUG_RETURN(ret),
    .CFG_SCR_WE(cwe), .CFG_SCR_IDX(cidx), .CFG_SCR_WDATA(cwd),
    .CFG_SCR_RDATA(crd), .DEBUG_IRQ(irq), .IN_DEBUG(in_dbg),
    .THREAD_RUN_EN(run_en), .GETREG_THREAD(gthr), .GETREG_INDEX(gidx));
  tdb_threads threads (.clk(clk), .go(go), .kind(kind), .thr(thr),
    .val(val), .ld(ld), .fetch(fetch), .mem(mem), .res(res), .call(call),
    .host(host), .ret(ret));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, entered right after a rising edge
  task automatic apb(logic w, logic [7:0] idx, logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk("pready_wait", 32'h1, 32'(n));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] idx, logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
  endtask
  task automatic rd(logic [7:0] idx, logic [31:0] exp, logic eerr);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0, d, e);
    chk("prdata", exp, d);
    chk("pslverr", {31'h0, eerr}, {31'h0, e});
  endtask
  // one thread event, then the expected debug mode level
  task automatic ev(logic [2:0] k, logic [2:0] t, logic [31:0] v,
                    logic l, logic hit);
    go <= 1'b1;
    kind <= k;
    thr <= t;
    val <= v;
    ld <= l;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    chk("in_debug", {31'h0, hit}, {31'h0, in_dbg});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h15, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b0);
    rd(8'h70, 32'h0, 1'b0);
    rd(8'h9c, 32'h0, 1'b0);
    chk("run_en", 32'hff, {24'h0, run_en});
    $display("test reset values done");
    wr(8'h13, 32'hffffffa5);
    wr(8'h14, 32'hffffffff);
    rd(8'h13, 32'ha5, 1'b0);
    rd(8'h14, 32'h1f, 1'b0);
    chk("getreg", 32'ha51f, {16'h0, gthr, 3'h0, gidx});
    rd(8'h17, 32'h0, 1'b1);
    $display("test operands done");
    ev(3'h0, 3'h4, 32'h0, 1'b0, 1'b1);
    rd(8'h15, 32'h1, 1'b0);
    ev(3'h5, 3'h0, 32'h0, 1'b0, 1'b0);
    ev(3'h1, 3'h5, 32'h0, 1'b0, 1'b1);
    rd(8'h15, 32'h502, 1'b0);
    ev(3'h5, 3'h0, 32'h0, 1'b0, 1'b0);
    $display("test host and call done");
    wr(8'h30, 32'h200);
    wr(8'h40, 32'hff0000);
    ev(3'h2, 3'h1, 32'h200, 1'b0, 1'b0);
    wr(8'h31, 32'h100);
    wr(8'h32, 32'h100);
    wr(8'h42, 32'hff0001);
    wr(8'h41, 32'hff0001);
    ev(3'h2, 3'h3, 32'h100, 1'b0, 1'b1);
    rd(8'h15, 32'h10303, 1'b0);
    ev(3'h5, 3'h0, 32'h0, 1'b0, 1'b0);
    $display("test instruction breakpoints done");
    wr(8'h53, 32'h200);
    wr(8'h63, 32'h2ff);
    wr(8'h73, 32'h400005);
    ev(3'h3, 3'h6, 32'h250, 1'b1, 1'b1);
    rd(8'h15, 32'h30604, 1'b0);
    rd(8'h16, 32'h250, 1'b0);
    ev(3'h5, 3'h0, 32'h0, 1'b0, 1'b0);
    $display("test data watchpoint done");
    wr(8'h80, 32'hff00);
    wr(8'h90, 32'h1200);
    wr(8'h9c, 32'h10001);
    ev(3'h4, 3'h1, 32'h12ab, 1'b0, 1'b0);
    ev(3'h4, 3'h0, 32'h12ab, 1'b0, 1'b1);
    rd(8'h15, 32'h5, 1'b0);
    rd(8'h16, 32'h12ab, 1'b0);
    ev(3'h5, 3'h0, 32'h0, 1'b0, 1'b0);
    $display("test resource watchpoint done");
    wr(8'h18, 32'h4);
    ev(3'h0, 3'h0, 32'h0, 1'b0, 1'b1);
    chk("run_en", 32'h0, {24'h0, run_en});
    ev(3'h5, 3'h0, 32'h0, 1'b0, 1'b0);
    chk("run_en", 32'hfb, {24'h0, run_en});
    $display("test stop mask done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h20 + i[7:0], {24'h5a5a00, i[7:0]});
      cidx <= i[2:0];
      repeat (2) @(posedge clk);
      chk("cfg_scratch", {24'h5a5a00, i[7:0]}, crd);
    end
    cwe <= 1'b1;
    cidx <= 3'h6;
    cwd <= 32'hc0ffee01;
    @(posedge clk);
    cwe <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h26, 32'hc0ffee01, 1'b0);
    $display("test scratch done");
    wrap_up();
  end
endmodule
